// File: tb/icw_props.sv
// Checker on the ports of the bus controller top module
`timescale 1ns/1ps
module icw_props (
	input wire logic        hclk,                  // Clock
	input wire logic        hresetn,               // Reset
	input wire logic        hreadyout,             // Ready
	input wire logic        hresp,                 // Response
	input wire logic [31:0] hrdata,                // Read data
	input wire logic        serial_clock_pin_in,   // Clock wire
	input wire logic        serial_clock_pin_out,  // Clock level
	input wire logic        serial_clock_pin_oe,   // Clock pull
	input wire logic        serial_data_pin_out,   // Data level
	input wire logic        serial_data_pin_oe,    // Data pull
	input wire logic        bus_interrupt_request  // Event
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Data pulled or let go while the clock wire is high
	sequence start_s; $rose(serial_data_pin_oe) && serial_clock_pin_in;
	endsequence
	sequence stop_s; $fell(serial_data_pin_oe) && serial_clock_pin_in;
	endsequence
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer");
	chk_rdata_hi: assert property (hrdata[31:8] == 24'h000000)
		else $error("read data high");
	chk_pin_low: assert property (!serial_clock_pin_out && !serial_data_pin_out)
		else $error("pin level");
	chk_irq_pulse: assert property (bus_interrupt_request
		|=> !bus_interrupt_request) else $error("irq width");
	chk_low_min: assert property ($rose(serial_clock_pin_oe)
		|-> serial_clock_pin_oe[*8]) else $error("short low");
	chk_start_clk: assert property (start_s
		|-> ##[1:400] serial_clock_pin_oe) else $error("no clock");
	chk_stop_quiet: assert property (stop_s
		|-> (!serial_clock_pin_oe)[*4]) else $error("clock after stop");
	chk_wait_hold: assert property (bus_interrupt_request &&
		!serial_clock_pin_in |-> serial_clock_pin_oe[*2])
		else $error("wait not held");
endmodule

// File: tb/icw_slave_model.sv
// Bus slave model that receives bytes and answers acknowledge
`timescale 1ns/1ps
module icw_slave_model (
	input wire logic  hclk,          // Clock
	input wire logic  scl,           // Clock wire
	input wire logic  sda,           // Data wire
	input wire logic  ack_en,        // Answer acknowledge
	output logic       sda_oe = 0,   // Pull data low
	output logic [7:0] rx_byte,      // Last byte
	output logic       rx_valid = 0  // Byte done
);
	logic       scl_q = 1, sda_q = 1; // Wire history
	logic [3:0] cnt = 4'h0;           // Bits in frame
	// Sample on clock rise, drive acknowledge on clock fall
	always @(posedge hclk) begin
		scl_q <= scl;
		sda_q <= sda;
		rx_valid <= 0;
		if (scl && scl_q && sda_q && !sda)
			cnt <= 4'h0;
		else if (scl && !scl_q) begin
			rx_byte <= {rx_byte[6:0], sda};
			rx_valid <= cnt == 4'h7;
			cnt <= cnt + 4'h1;
		end else if (!scl && scl_q) begin
			sda_oe <= cnt == 4'h8 && ack_en;
			if (cnt == 4'h9) cnt <= 4'h0;
		end
	end
endmodule

// File: tb/tb.sv
// Testbench: register access and master write traffic
`timescale 1ns/1ps
module tb import icw_pkg::*;;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ack_en = 0;
	logic [7:0] haddr = 8'h00, rxb, exp_q[$];
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, q;
	logic hrdy, irq, c_oe, d_oe, s_oe, rxv;
	logic [15:0] rnd = 16'h0269;
	int err_count = 0, cmp_count = 0, cyc = 0, n = 0;
	wire scl = !c_oe;
	wire sda = !(d_oe | s_oe);
	always #20 hclk = ~hclk;
	icw_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(),
		.hrdata(hrdata), .serial_clock_pin_in(scl),
		.serial_clock_pin_out(), .serial_clock_pin_oe(c_oe),
		.serial_data_pin_in(sda), .serial_data_pin_out(),
		.serial_data_pin_oe(d_oe), .bus_interrupt_request(irq));
	icw_slave_model i_pm (.hclk(hclk), .scl(scl), .sda(sda),
		.ack_en(ack_en), .sda_oe(s_oe), .rx_byte(rxb), .rx_valid(rxv));
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test;
		if (err_count == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// One single word transfer, read data left in q
	task automatic bus(input logic w, input logic [7:0] a, input [31:0] d);
		hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
		do @(posedge hclk); while (hrdy !== 1'b1);
		hsel <= 0; htrans <= 2'h0; hwdata <= d;
		do @(posedge hclk); while (hrdy !== 1'b1);
		q = hrdata;
	endtask
	task automatic lvl(input logic v);
		do begin @(posedge hclk); n++; end while (scl !== v);
	endtask
	task automatic wirq;
		do @(posedge hclk); while (irq !== 1'b1);
	endtask
	// Received bytes against the queue, and the hang limit
	always @(posedge hclk) begin
		cyc++;
		if (rxv === 1'b1) chk("rx byte", exp_q.pop_front(), rxb);
		if (cyc == 20000) begin err_count++; stop_test; end
	end
	initial begin
		logic [8:0] mv [3] = '{ICW_M_44, ICW_M_48, ICW_M_24};
		logic [4:0] cfg [3] = '{5'h03, 5'h09, 5'h1f};
		repeat (8) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		bus(0, ICW_CLK_OFS, 0); chk("clk reset", 0, q);
		bus(0, 8'h1c, 0); chk("unmapped", 0, q);
		bus(1, ICW_EXP_OFS, 1);
		bus(0, ICW_STAT_OFS, 0); chk("prohibited", 1, q[ST_BAD]);
		for (int i = 0; i < 3; i++) begin
			ack_en <= i != 1;
			bus(1, ICW_CTRL_OFS, 0);
			bus(1, ICW_CLK_OFS, cfg[i][3:0]);
			bus(1, ICW_EXP_OFS, cfg[i][4]);
			bus(1, ICW_CTRL_OFS, i == 1 ? 32'h90 : 32'h98);
			rnd = nxt(rnd); exp_q.push_back({rnd[6:0], 1'b0});
			bus(1, ICW_SHIFT_OFS, {rnd[6:0], 1'b0});
			bus(1, ICW_CTRL_OFS, i == 1 ? 32'h92 : 32'h9a);
			lvl(0); lvl(1); n = 0; lvl(0); lvl(1);
			chk("period", 1, n >= mv[i] && n < mv[i] + 4);
			wirq; chk("clock held", 0, scl);
			bus(0, ICW_STAT_OFS, 0); chk("ack", ack_en, q[ST_ACKD]);
			rnd = nxt(rnd); exp_q.push_back(rnd[7:0]);
			bus(1, ICW_SHIFT_OFS, rnd[7:0]);
			wirq;
			if (i < 2) begin
				bus(1, ICW_CTRL_OFS, 32'h99);
				wirq;
				bus(0, ICW_STAT_OFS, 0); chk("stop", 1, q[ST_SPD]);
			end else begin
				bus(1, ICW_CTRL_OFS, 32'hd8);
				lvl(1); chk("exit", 1, sda);
			end
		end
		chk("rx left", 0, exp_q.size());
		stop_test;
	end
endmodule
bind icw_top icw_props i_props (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.serial_clock_pin_in(serial_clock_pin_in),
	.serial_clock_pin_out(serial_clock_pin_out),
	.serial_clock_pin_oe(serial_clock_pin_oe),
	.serial_data_pin_out(serial_data_pin_out),
	.serial_data_pin_oe(serial_data_pin_oe),
	.bus_interrupt_request(bus_interrupt_request));

// File: verilog/icw_cond_detect.sv
// Line edge, start and stop detector for the two bus wires
`timescale 1ns/1ps
module icw_cond_detect (
	input  wire logic hclk,      // System clock
	input  wire logic hresetn,   // Async reset, active low
	input  wire logic scl_in,    // Clock wire level
	input  wire logic sda_in,    // Data wire level
	output logic      scl_rise,  // Clock wire went high
	output logic      scl_fall,  // Clock wire went low
	output logic      start_det, // Data fell while clock high
	output logic      stop_det   // Data rose while clock high
);

	// ==========================================================
	// Previous levels
	logic scl_q_r; // Clock level one cycle ago
	logic sda_q_r; // Data level one cycle ago

	// Compare present and past levels
	always_comb begin
		scl_rise  = scl_in && !scl_q_r;
		scl_fall  = !scl_in && scl_q_r;
		start_det = scl_in && scl_q_r && sda_q_r && !sda_in;
		stop_det  = scl_in && scl_q_r && !sda_q_r && sda_in;
	end

	// Idle bus reads high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_in;
			sda_q_r <= sda_in;
		end
	end

endmodule

// File: verilog/icw_divider.sv
// Half-period divider for the master serial clock
`timescale 1ns/1ps
module icw_divider import icw_pkg::*; #(
	parameter int W = ICW_DIV_W
) (
	input  wire logic         hclk,    // System clock
	input  wire logic         hresetn, // Async reset, active low
	input  wire logic         restart, // Start a fresh half period
	input  wire logic         hold,    // Freeze the count
	input  wire logic [W-1:0] half,    // Cycles per half period
	output logic              tick     // End of a half period
);

	// ==========================================================
	// Counter
	logic [W-1:0] cnt_r;   // Cycles spent in this half
	logic [W-1:0] cnt_nxt; // Next count

	// Tick at the last cycle of the half, frozen while held
	always_comb begin
		tick    = (cnt_r >= half - W'(1)) && !hold && !restart;
		cnt_nxt = cnt_r;
		if (restart || tick) begin
			cnt_nxt = '0;
		end else if (!hold) begin
			cnt_nxt = cnt_r + W'(1);
		end
	end

	// Register the count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule

// File: verilog/icw_pkg.sv
// Package: register map, field positions and clock divider table
package icw_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] ICW_CTRL_OFS  = 8'h00; // Bus control
	localparam logic [7:0] ICW_STAT_OFS  = 8'h04; // Bus status
	localparam logic [7:0] ICW_SHIFT_OFS = 8'h08; // Shift register
	localparam logic [7:0] ICW_CLK_OFS   = 8'h0c; // Clock select
	localparam logic [7:0] ICW_EXP_OFS   = 8'h10; // Function expansion
	localparam logic [7:0] ICW_SADR_OFS  = 8'h14; // Own slave address

	// ==========================================================
	// Control bit positions
	localparam int CTL_STOP  = 0; // Stop request
	localparam int CTL_START = 1; // Start request
	localparam int CTL_ACKEN = 2; // Acknowledge enable
	localparam int CTL_WTIM  = 3; // Wait timing select
	localparam int CTL_SPIE  = 4; // Stop interrupt enable
	localparam int CTL_WREL  = 5; // Wait release
	localparam int CTL_EXIT  = 6; // Communication exit
	localparam int CTL_EN    = 7; // Operation enable

	// Status bit positions
	localparam int ST_SPD  = 0; // Stop detected
	localparam int ST_STD  = 1; // Start detected
	localparam int ST_ACKD = 2; // Acknowledge detected
	localparam int ST_TRC  = 3; // Transmit/receive
	localparam int ST_WAIT = 4; // Wait in progress
	localparam int ST_MST  = 5; // Master role
	localparam int ST_BAD  = 6; // Prohibited clock setting
	localparam int ST_BUSY = 7; // Taking part in a transfer

	// Clock select and expansion bit positions
	localparam int CS_LO   = 0; // Clock select low bit
	localparam int CS_HI   = 1; // Clock select high bit
	localparam int CS_FAST = 3; // Fast mode select
	localparam int EXP_CLX = 0; // Expansion clock bit

	// ==========================================================
	// Reset values and byte framing
	localparam logic [7:0] ICW_RST_BYTE = 8'h00; // Register reset
	localparam logic [7:0] ICW_ALL_ONES = 8'hff; // Released data
	localparam logic [3:0] ICW_CNT_PRE  = 4'hf;  // Before bit one
	localparam logic [3:0] ICW_CNT_BYTE = 4'h8;  // Eight bits done
	localparam logic [3:0] ICW_CNT_ACK  = 4'h9;  // Ninth bit done
	localparam logic [3:0] ICW_EXT_LO   = 4'h0;  // Extension prefix
	localparam logic [3:0] ICW_EXT_HI   = 4'hf;  // Extension prefix

	// ==========================================================
	// Divider values m
	localparam int ICW_DIV_W = 9;
	localparam logic [8:0] ICW_M_24  = 9'h018;
	localparam logic [8:0] ICW_M_44  = 9'h02c;
	localparam logic [8:0] ICW_M_48  = 9'h030;
	localparam logic [8:0] ICW_M_88  = 9'h058;
	localparam logic [8:0] ICW_M_96  = 9'h060;
	localparam logic [8:0] ICW_M_172 = 9'h0ac;
	localparam logic [8:0] ICW_M_344 = 9'h158;

	// Returns {prohibited, m} for a clock setting
	function automatic logic [9:0] icw_div_sel(input logic clx,
		input logic fast, input logic hi, input logic lo);
		logic [9:0] r;
		r = {1'b1, ICW_M_88};
		case ({clx, fast, hi, lo})
			4'b0000: r = {1'b0, ICW_M_88};
			4'b0001: r = {1'b0, ICW_M_172};
			4'b0010: r = {1'b0, ICW_M_344};
			4'b0011: r = {1'b0, ICW_M_44};
			4'b0100, 4'b0101, 4'b1100, 4'b1101: r = {1'b0, ICW_M_48};
			4'b0110: r = {1'b0, ICW_M_96};
			4'b0111, 4'b1111: r = {1'b0, ICW_M_24};
			default: r = {1'b1, ICW_M_88};
		endcase
		return r;
	endfunction

endpackage

// File: verilog/icw_top.sv
// Two-wire bus controller: clocking, acknowledge, stop and wait
//
// Notes on behaviour
// - Master clock period is m system clocks
// - Normal mode selects 88, 172, 344, 44
// - Fast mode selects 48, 96 or 24
// - Expansion bit allows only 48 or 24
// - Receiver pulls data low on ninth clock
// - Transmitter records returned acknowledge in status
// - Acknowledge enable makes receive acknowledges automatic
// - Direction flag loads from address eighth bit
// - Own address always acknowledged, others not
// - Extension code acknowledged only if enabled
// - Acknowledge enable must precede wait release
// - Master ends unacknowledged transfer with stop
// - Stop is data rising while clock high
// - Stop request emits stop; detection flags it
// - Waiting device holds clock wire low
// - Shift write, release, or start or stop while master end wait
// - Clearing enable stops and releases wait
// - Exit bit withdraws and cancels any wait
`timescale 1ns/1ps
module icw_top import icw_pkg::*; (
	input  wire logic        hclk,                  // System clock
	input  wire logic        hresetn,               // Async reset
	input  wire logic        hsel,                  // Slave select
	input  wire logic [7:0]  haddr,                 // Byte address
	input  wire logic [1:0]  htrans,                // Transfer type
	input  wire logic        hwrite,                // Write when high
	input  wire logic [2:0]  hsize,                 // Word only
	input  wire logic [31:0] hwdata,                // Write data
	input  wire logic        hready,                // Bus ready
	output logic             hreadyout,             // Always ready
	output logic             hresp,                 // Always OKAY
	output logic [31:0]      hrdata,                // Read data
	input  wire logic        serial_clock_pin_in,   // Clock wire
	output logic             serial_clock_pin_out,  // Drives low
	output logic             serial_clock_pin_oe,   // Pull clock low
	input  wire logic        serial_data_pin_in,    // Data wire
	output logic             serial_data_pin_out,   // Drives low
	output logic             serial_data_pin_oe,    // Pull data low
	output logic             bus_interrupt_request  // Event pulse
);

	// ==========================================================
	// Master sequencer states
	typedef enum logic [7:0] {
		M_IDLE  = 8'b00000001, // Not master
		M_START = 8'b00000010, // Data low, clock high
		M_LOW   = 8'b00000100, // Clock low half
		M_HIGH  = 8'b00001000, // Clock high half
		M_STOPA = 8'b00010000, // Data low under low clock
		M_STOPB = 8'b00100000, // Clock high, then data up
		M_RSA   = 8'b01000000, // Data up under low clock
		M_RSB   = 8'b10000000  // Clock high, then data down
	} icw_mstate_t;

	// ==========================================================
	// Bus slave state
	logic        aph_wr_r, aph_wr_nxt;   // Write data phase pending
	logic [7:0]  aph_ofs_r, aph_ofs_nxt; // Captured offset
	logic [31:0] hrdata_r, hrdata_nxt;   // Registered read data
	logic        take;                   // Address phase accepted
	logic [7:0]  rd_byte;                // Selected register value

	// Software settings
	logic       en_r, en_nxt;       // Operation enable
	logic       spie_r, spie_nxt;   // Stop interrupt enable
	logic       wtim_r, wtim_nxt;   // Nine-clock wait when high
	logic       acken_r, acken_nxt; // Acknowledge enable
	logic [2:0] clk_r, clk_nxt;     // {fast, hi, lo}
	logic       clx_r, clx_nxt;     // Expansion clock bit
	logic [6:0] sadr_r, sadr_nxt;   // Own slave address

	// Byte engine state
	logic [7:0] shift_r, shift_nxt;     // Shift register
	logic [3:0] cnt_r, cnt_nxt;         // Falling edges in byte
	logic       active_r, active_nxt;   // Taking part
	logic       addr_r, addr_nxt;       // Address byte phase
	logic       ext_r, ext_nxt;         // Extension code seen
	logic       trc_r, trc_nxt;         // Transmitting
	logic       ackd_r, ackd_nxt;       // Acknowledge detected
	logic       wait_r, wait_nxt;       // Holding clock low
	logic       drv_r, drv_nxt;         // Pull data low
	logic       spd_r, spd_nxt;         // Stop detected
	logic       std_r, std_nxt;         // Start detected
	logic       irq_r, irq_nxt;         // Interrupt pulse

	// Master sequencer state
	icw_mstate_t mst_state_r, mst_state_nxt; // Sequencer state
	logic        mst_r, mst_nxt;             // Master role
	logic        mscl_r, mscl_nxt;           // Master pulls clock
	logic        msda_r, msda_nxt;           // Master pulls data
	logic        spend_r, spend_nxt;         // Start pending
	logic        ppend_r, ppend_nxt;         // Stop pending
	logic        rpend_r, rpend_nxt;         // Restart pending

	// Helpers
	logic [9:0] div_sel;                 // {bad, m}
	logic [8:0] half;                    // Half period cycles
	logic       tick, div_restart, div_hold; // Divider controls
	logic       scl_rise, scl_fall, start_det, stop_det; // Events
	logic       wr_ctrl, wr_shift, wr_clk, wr_exp, wr_sadr; // Strobes
	logic       match, ext_code, ack_ok; // Address decode
	logic       cond_ph;                 // Master owns the data wire

	// ==========================================================
	// Submodules
	icw_divider #(.W(ICW_DIV_W)) u_div (
		.hclk    (hclk),
		.hresetn (hresetn),
		.restart (div_restart),
		.hold    (div_hold),
		.half    (half),
		.tick    (tick)
	);

	icw_cond_detect u_det (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.scl_in    (serial_clock_pin_in),
		.sda_in    (serial_data_pin_in),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// ==========================================================
	// AHB-Lite slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;
	assign take      = hsel && hready && htrans[1];
	assign wr_ctrl   = aph_wr_r && (aph_ofs_r == ICW_CTRL_OFS);
	assign wr_shift  = aph_wr_r && (aph_ofs_r == ICW_SHIFT_OFS);
	assign wr_clk    = aph_wr_r && (aph_ofs_r == ICW_CLK_OFS);
	assign wr_exp    = aph_wr_r && (aph_ofs_r == ICW_EXP_OFS);
	assign wr_sadr   = aph_wr_r && (aph_ofs_r == ICW_SADR_OFS);

	// Read mux; trigger bits and unmapped offsets read zero
	always_comb begin
		rd_byte = ICW_RST_BYTE;
		case (haddr)
			ICW_CTRL_OFS: begin
				rd_byte[CTL_EN]    = en_r;
				rd_byte[CTL_SPIE]  = spie_r;
				rd_byte[CTL_WTIM]  = wtim_r;
				rd_byte[CTL_ACKEN] = acken_r;
			end
			ICW_STAT_OFS: begin
				rd_byte[ST_SPD]  = spd_r;
				rd_byte[ST_STD]  = std_r;
				rd_byte[ST_ACKD] = ackd_r;
				rd_byte[ST_TRC]  = trc_r;
				rd_byte[ST_WAIT] = wait_r;
				rd_byte[ST_MST]  = mst_r;
				rd_byte[ST_BAD]  = div_sel[9];
				rd_byte[ST_BUSY] = active_r;
			end
			ICW_SHIFT_OFS: rd_byte = shift_r;
			ICW_CLK_OFS: begin
				rd_byte[CS_FAST] = clk_r[2];
				rd_byte[CS_HI]   = clk_r[1];
				rd_byte[CS_LO]   = clk_r[0];
			end
			ICW_EXP_OFS:  rd_byte[EXP_CLX] = clx_r;
			ICW_SADR_OFS: rd_byte = {sadr_r, 1'b0};
			default:      rd_byte = ICW_RST_BYTE;
		endcase
		aph_wr_nxt  = take && hwrite;
		aph_ofs_nxt = take ? haddr : aph_ofs_r;
		hrdata_nxt  = (take && !hwrite) ? {24'h000000, rd_byte} : hrdata_r;
	end

	// ==========================================================
	// Clock selection and address decode
	assign div_sel  = icw_div_sel(clx_r, clk_r[2], clk_r[1],
		clk_r[0]);
	assign half     = {1'b0, div_sel[8:1]};
	assign match    = (shift_r[7:1] == sadr_r);
	assign ext_code = (shift_r[7:4] == ICW_EXT_LO) ||
		(shift_r[7:4] == ICW_EXT_HI);
	assign ack_ok   = addr_r ? (ext_r ? acken_r : (match && !mst_r))
		: acken_r;
	assign cond_ph  = mst_state_r[4] || mst_state_r[5] ||
		mst_state_r[6] || mst_state_r[7];

	// Data drive for the bit after c completed edges
	function automatic logic drive_calc(input logic [3:0] c,
		input logic [7:0] sh, input logic trc, input logic ok);
		logic d;
		d = (c == ICW_CNT_BYTE) ? (!trc && ok) : (trc && !sh[7]);
		return d;
	endfunction

	// ==========================================================
	// Settings and byte engine next state
	always_comb begin
		en_nxt     = en_r;
		spie_nxt   = spie_r;
		wtim_nxt   = wtim_r;
		acken_nxt  = acken_r;
		clk_nxt    = clk_r;
		clx_nxt    = clx_r;
		sadr_nxt   = sadr_r;
		shift_nxt  = shift_r;
		cnt_nxt    = cnt_r;
		active_nxt = active_r;
		addr_nxt   = addr_r;
		ext_nxt    = ext_r;
		trc_nxt    = trc_r;
		ackd_nxt   = ackd_r;
		wait_nxt   = wait_r;
		drv_nxt    = drv_r;
		spd_nxt    = spd_r;
		std_nxt    = std_r;
		irq_nxt    = 1'b0;
		// Register writes; clock bits are meant for a disabled core
		if (wr_ctrl) begin
			en_nxt    = hwdata[CTL_EN];
			spie_nxt  = hwdata[CTL_SPIE];
			wtim_nxt  = hwdata[CTL_WTIM];
			acken_nxt = hwdata[CTL_ACKEN];
		end
		if (wr_clk) begin
			clk_nxt = {hwdata[CS_FAST], hwdata[CS_HI], hwdata[CS_LO]};
		end
		if (wr_exp) begin
			clx_nxt = hwdata[EXP_CLX];
		end
		if (wr_sadr) begin
			sadr_nxt = hwdata[7:1];
		end
		// Bus events
		if (start_det) begin
			active_nxt = 1'b1;
			addr_nxt   = 1'b1;
			ext_nxt    = 1'b0;
			cnt_nxt    = ICW_CNT_PRE;
			trc_nxt    = mst_r;
			std_nxt    = 1'b1;
			spd_nxt    = 1'b0;
			wait_nxt   = 1'b0;
			drv_nxt    = 1'b0;
		end else if (active_r && scl_rise && cnt_r == ICW_CNT_BYTE) begin
			if (trc_r) begin
				ackd_nxt = !serial_data_pin_in;
			end
		end else if (active_r && scl_rise) begin
			shift_nxt = {shift_r[6:0], serial_data_pin_in};
		end else if (active_r && scl_fall) begin
			if (cnt_r == ICW_CNT_PRE) begin
				cnt_nxt = 4'h0;
			end else if (cnt_r == ICW_CNT_ACK) begin
				cnt_nxt = 4'h1;
			end else begin
				cnt_nxt = cnt_r + 4'h1;
			end
			drv_nxt = drive_calc(cnt_nxt, shift_r, trc_r, ack_ok);
			if (cnt_nxt == ICW_CNT_BYTE) begin
				if (addr_r && !mst_r && ext_code) begin
					ext_nxt  = 1'b1;
					wait_nxt = 1'b1;
				end else if (!addr_r && !wtim_r) begin
					wait_nxt = 1'b1;
				end
			end else if (cnt_nxt == ICW_CNT_ACK) begin
				if (addr_r) begin
					addr_nxt = 1'b0;
					if (mst_r) begin
						trc_nxt  = !shift_r[0];
						wait_nxt = 1'b1;
					end else if (match && !ext_r) begin
						trc_nxt  = shift_r[0];
						wait_nxt = 1'b1;
					end else if (ext_r) begin
						trc_nxt = 1'b0;
					end else begin
						active_nxt = 1'b0;
					end
				end else if (wtim_r) begin
					wait_nxt = 1'b1;
				end
			end
			if (wait_nxt && !wait_r) begin
				drv_nxt = 1'b0;
				irq_nxt = 1'b1;
			end
		end
		// Wait release by the first action seen
		if (wr_shift) begin
			shift_nxt = hwdata[7:0];
		end
		if (wr_ctrl && hwdata[CTL_WREL] && trc_r && wait_r) begin
			shift_nxt = ICW_ALL_ONES;
		end
		if (wait_r && (wr_shift || (wr_ctrl && (hwdata[CTL_WREL] ||
			(mst_r && (hwdata[CTL_START] || hwdata[CTL_STOP]))))))
		begin
			wait_nxt = 1'b0;
			drv_nxt  = drive_calc(cnt_r, shift_nxt, trc_r, ack_ok);
			if (wr_ctrl && mst_r && (hwdata[CTL_START] ||
				hwdata[CTL_STOP])) begin
				drv_nxt = 1'b0;
			end
		end
		if (stop_det) begin
			spd_nxt    = 1'b1;
			std_nxt    = 1'b0;
			active_nxt = 1'b0;
			wait_nxt   = 1'b0;
			drv_nxt    = 1'b0;
			irq_nxt    = spie_r;
		end
		// Disable or exit withdraws from the transfer
		if (!en_r || (wr_ctrl && hwdata[CTL_EXIT])) begin
			active_nxt = 1'b0;
			wait_nxt   = 1'b0;
			drv_nxt    = 1'b0;
			addr_nxt   = 1'b0;
			trc_nxt    = 1'b0;
		end
	end

	// ==========================================================
	// Master sequencer next state
	always_comb begin
		mst_state_nxt = mst_state_r;
		mst_nxt       = mst_r;
		mscl_nxt      = mscl_r;
		msda_nxt      = msda_r;
		spend_nxt     = spend_r;
		ppend_nxt     = ppend_r;
		rpend_nxt     = rpend_r;
		div_restart   = 1'b0;
		div_hold      = 1'b0;
		// Requests from the control register
		if (wr_ctrl && hwdata[CTL_START]) begin
			if (mst_r) begin
				rpend_nxt = 1'b1;
			end else begin
				spend_nxt = 1'b1;
			end
		end
		if (wr_ctrl && hwdata[CTL_STOP] && mst_r) begin
			ppend_nxt = 1'b1;
		end
		case (mst_state_r)
			M_IDLE: begin
				mscl_nxt = 1'b0;
				msda_nxt = 1'b0;
				if (spend_r && !div_sel[9] && !active_r &&
					serial_clock_pin_in && serial_data_pin_in) begin
					msda_nxt      = 1'b1;
					mst_nxt       = 1'b1;
					spend_nxt     = 1'b0;
					div_restart   = 1'b1;
					mst_state_nxt = M_START;
				end
			end
			M_START: begin
				if (tick) begin
					mscl_nxt      = 1'b1;
					msda_nxt      = 1'b0;
					mst_state_nxt = M_LOW;
				end
			end
			M_LOW: begin
				div_hold = wait_r;
				if (tick && ppend_r) begin
					msda_nxt      = 1'b1;
					ppend_nxt     = 1'b0;
					mst_state_nxt = M_STOPA;
				end else if (tick && rpend_r) begin
					rpend_nxt     = 1'b0;
					mst_state_nxt = M_RSA;
				end else if (tick) begin
					mscl_nxt      = 1'b0;
					mst_state_nxt = M_HIGH;
				end
			end
			M_HIGH: begin
				div_hold = !serial_clock_pin_in;
				if (tick) begin
					mscl_nxt      = 1'b1;
					mst_state_nxt = M_LOW;
				end
			end
			M_STOPA: begin
				if (tick) begin
					mscl_nxt      = 1'b0;
					mst_state_nxt = M_STOPB;
				end
			end
			M_STOPB: begin
				div_hold = !serial_clock_pin_in;
				if (tick) begin
					msda_nxt      = 1'b0;
					mst_nxt       = 1'b0;
					mst_state_nxt = M_IDLE;
				end
			end
			M_RSA: begin
				if (tick) begin
					mscl_nxt      = 1'b0;
					mst_state_nxt = M_RSB;
				end
			end
			M_RSB: begin
				div_hold = !serial_clock_pin_in;
				if (tick) begin
					msda_nxt      = 1'b1;
					mst_state_nxt = M_START;
				end
			end
			default: mst_state_nxt = M_IDLE;
		endcase
		if (!en_r || (wr_ctrl && hwdata[CTL_EXIT])) begin
			mst_state_nxt = M_IDLE;
			mst_nxt       = 1'b0;
			mscl_nxt      = 1'b0;
			msda_nxt      = 1'b0;
			spend_nxt     = 1'b0;
			ppend_nxt     = 1'b0;
			rpend_nxt     = 1'b0;
		end
	end

	// ==========================================================
	// Open-drain pins: only ever pull low
	assign serial_clock_pin_out  = 1'b0;
	assign serial_data_pin_out   = 1'b0;
	assign serial_clock_pin_oe   = mscl_r || wait_r;
	assign serial_data_pin_oe    = msda_r || (drv_r && !cond_ph);
	assign bus_interrupt_request = irq_r;

	// ==========================================================
	// State registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_wr_r    <= 1'b0;
			aph_ofs_r   <= ICW_RST_BYTE;
			hrdata_r    <= 32'h00000000;
			en_r        <= 1'b0;
			spie_r      <= 1'b0;
			wtim_r      <= 1'b0;
			acken_r     <= 1'b0;
			clk_r       <= 3'h0;
			clx_r       <= 1'b0;
			sadr_r      <= 7'h00;
			shift_r     <= ICW_RST_BYTE;
			cnt_r       <= ICW_CNT_PRE;
			active_r    <= 1'b0;
			addr_r      <= 1'b0;
			ext_r       <= 1'b0;
			trc_r       <= 1'b0;
			ackd_r      <= 1'b0;
			wait_r      <= 1'b0;
			drv_r       <= 1'b0;
			spd_r       <= 1'b0;
			std_r       <= 1'b0;
			irq_r       <= 1'b0;
			mst_state_r <= M_IDLE;
			mst_r       <= 1'b0;
			mscl_r      <= 1'b0;
			msda_r      <= 1'b0;
			spend_r     <= 1'b0;
			ppend_r     <= 1'b0;
			rpend_r     <= 1'b0;
		end else begin
			aph_wr_r    <= aph_wr_nxt;
			aph_ofs_r   <= aph_ofs_nxt;
			hrdata_r    <= hrdata_nxt;
			en_r        <= en_nxt;
			spie_r      <= spie_nxt;
			wtim_r      <= wtim_nxt;
			acken_r     <= acken_nxt;
			clk_r       <= clk_nxt;
			clx_r       <= clx_nxt;
			sadr_r      <= sadr_nxt;
			shift_r     <= shift_nxt;
			cnt_r       <= cnt_nxt;
			active_r    <= active_nxt;
			addr_r      <= addr_nxt;
			ext_r       <= ext_nxt;
			trc_r       <= trc_nxt;
			ackd_r      <= ackd_nxt;
			wait_r      <= wait_nxt;
			drv_r       <= drv_nxt;
			spd_r       <= spd_nxt;
			std_r       <= std_nxt;
			irq_r       <= irq_nxt;
			mst_state_r <= mst_state_nxt;
			mst_r       <= mst_nxt;
			mscl_r      <= mscl_nxt;
			msda_r      <= msda_nxt;
			spend_r     <= spend_nxt;
			ppend_r     <= ppend_nxt;
			rpend_r     <= rpend_nxt;
		end
	end

endmodule
